//--- qnio_pkg.sv
// Package with register map, fields and the port one reset value of the nibble ports
package qnio_pkg;
    localparam logic [7:0] ADDR_PORT1 = 8'h00;
    localparam logic [7:0] ADDR_PORT2 = 8'h04;
    localparam logic [7:0] ADDR_PORT3 = 8'h08;
    localparam logic [7:0] ADDR_BITOP = 8'h0C;
    localparam logic [7:0] ADDR_TEST = 8'h10;
    localparam logic [7:0] ADDR_STBY = 8'h14;
    // Decoded register codes
    localparam logic [2:0] DEC_PORT1 = 3'h0;
    localparam logic [2:0] DEC_PORT2 = 3'h1;
    localparam logic [2:0] DEC_PORT3 = 3'h2;
    localparam logic [2:0] DEC_BITOP = 3'h3;
    localparam logic [2:0] DEC_TEST = 3'h4;
    localparam logic [2:0] DEC_STBY = 3'h5;
    localparam logic [2:0] DEC_NONE = 3'h7;
    // Bit select field: [1:0] bit, [3:2] port; set flag at 4; level at 4
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 3;
    localparam int SET_POS = 4;
    localparam int LEVEL_POS = 4;
    localparam int HALT_POS = 0;
    localparam int WAKE_POS = 3;
    localparam logic [3:0] PORT1_RESET = 4'hF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- qnio_ports.sv
// Three nibble-wide general purpose ports with an AXI4-Lite register slave
// Notes on behaviour
// - Port read returns all four pins of the chosen port as one nibble.
// - Port write loads all four output latches of the chosen port at once.
// - Bit test reports the level of one chosen pin for branching.
// - Bit set or clear changes one latch and leaves the other three alone.
// - Pin three of port one also releases the halt standby mode.
// - Port two works like port one but has no standby role.
// - Each port one pin is open drain or pulled up, chosen per bit.
// - Port two drives high or low during reset, one choice for all pins.
`timescale 1ns/1ps
module qnio_ports #(
    parameter logic [3:0] P1_PULLUP = 4'h0,
    parameter logic [3:0] P2_PULLUP = 4'h0,
    parameter logic [3:0] P3_PULLUP = 4'h0,
    parameter logic P2_RESET_HIGH = 1'b1,
    parameter logic P3_RESET_HIGH = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] port_one_pins_in,
    output logic [3:0] port_one_pins_out,
    output logic [3:0] port_one_pins_oe_n,
    output logic [3:0] port_one_pullup_en,
    input wire logic [3:0] port_two_pins_in,
    output logic [3:0] port_two_pins_out,
    output logic [3:0] port_two_pins_oe_n,
    output logic [3:0] port_two_pullup_en,
    input wire logic [3:0] port_three_pins_in,
    output logic [3:0] port_three_pins_out,
    output logic [3:0] port_three_pins_oe_n,
    output logic [3:0] port_three_pullup_en,
    output logic standby
);
    localparam logic [11:0] LAT_RESET = {{4{P3_RESET_HIGH}}, {4{P2_RESET_HIGH}},
        qnio_pkg::PORT1_RESET};

    function automatic logic [2:0] qnio_dec(input logic [7:0] a);
        case (a)
            qnio_pkg::ADDR_PORT1: qnio_dec = qnio_pkg::DEC_PORT1;
            qnio_pkg::ADDR_PORT2: qnio_dec = qnio_pkg::DEC_PORT2;
            qnio_pkg::ADDR_PORT3: qnio_dec = qnio_pkg::DEC_PORT3;
            qnio_pkg::ADDR_BITOP: qnio_dec = qnio_pkg::DEC_BITOP;
            qnio_pkg::ADDR_TEST: qnio_dec = qnio_pkg::DEC_TEST;
            qnio_pkg::ADDR_STBY: qnio_dec = qnio_pkg::DEC_STBY;
            default: qnio_dec = qnio_pkg::DEC_NONE;
        endcase
    endfunction

    logic [11:0] sync1_r;
    logic [11:0] sync2_r;
    logic [11:0] lat_r;
    logic [11:0] lat_nxt;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic aw_ok_r;
    logic w_ok_r;
    logic [3:0] test_sel_r;
    logic halt_r;
    logic halt_nxt;

    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 12'h000;
            sync2_r <= 12'h000;
        end else begin
            sync1_r <= {port_three_pins_in, port_two_pins_in, port_one_pins_in};
            sync2_r <= sync1_r;
        end
    end

    // Write channel decode
    wire wr_do = aw_ok_r && w_ok_r && !s_axi_bvalid;
    wire [2:0] wr_dec = qnio_dec(awaddr_r);
    wire [3:0] wr_sel = wdata_r[qnio_pkg::SEL_MSB:qnio_pkg::SEL_LSB];
    wire wr_set = wdata_r[qnio_pkg::SET_POS];
    wire [1:0] wr_port = wr_sel[3:2];
    wire bitop_ok = wr_port != 2'h3;
    wire [2:0] rd_dec = qnio_dec(s_axi_araddr);
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [3:0] test_sel_use = (wr_do && wr_dec == qnio_pkg::DEC_TEST) ? wr_sel : test_sel_r;
    wire test_level = sync2_r[test_sel_r];
    wire wake_low = !sync2_r[qnio_pkg::WAKE_POS];

    // Latch update: nibble load or single bit set and clear
    always_comb begin
        lat_nxt = lat_r;
        if (wr_do) begin
            case (wr_dec)
                qnio_pkg::DEC_PORT1: lat_nxt[3:0] = wdata_r[3:0];
                qnio_pkg::DEC_PORT2: lat_nxt[7:4] = wdata_r[3:0];
                qnio_pkg::DEC_PORT3: lat_nxt[11:8] = wdata_r[3:0];
                qnio_pkg::DEC_BITOP: begin
                    if (bitop_ok) begin
                        lat_nxt[wr_sel] = wr_set;
                    end
                end
                default: lat_nxt = lat_r;
            endcase
        end
    end

    // Halt entered by software, left when pin three of port one goes low
    always_comb begin
        halt_nxt = halt_r;
        if (halt_r && wake_low) begin
            halt_nxt = 1'b0;
        end
        if (wr_do && wr_dec == qnio_pkg::DEC_STBY && wdata_r[qnio_pkg::HALT_POS]) begin
            halt_nxt = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_r <= LAT_RESET;
            halt_r <= 1'b0;
            test_sel_r <= 4'h0;
        end else begin
            lat_r <= lat_nxt;
            halt_r <= halt_nxt;
            test_sel_r <= test_sel_use;
        end
    end

    // Pin drivers: pull-down on when latch is low, else pin floats or is pulled up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_one_pullup_en <= P1_PULLUP;
            port_two_pullup_en <= P2_PULLUP;
            port_three_pullup_en <= P3_PULLUP;
            port_one_pins_out <= 4'h0;
            port_two_pins_out <= 4'h0;
            port_three_pins_out <= 4'h0;
        end else begin
            port_one_pullup_en <= P1_PULLUP;
            port_two_pullup_en <= P2_PULLUP;
            port_three_pullup_en <= P3_PULLUP;
            port_one_pins_out <= 4'h0;
            port_two_pins_out <= 4'h0;
            port_three_pins_out <= 4'h0;
        end
    end
    assign port_one_pins_oe_n = lat_r[3:0];
    assign port_two_pins_oe_n = lat_r[7:4];
    assign port_three_pins_oe_n = lat_r[11:8];
    assign standby = halt_r;

    // AXI4-Lite write side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= qnio_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_dec == qnio_pkg::DEC_NONE) ? qnio_pkg::RESP_SLVERR
                    : qnio_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= qnio_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= qnio_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (rd_dec)
                qnio_pkg::DEC_PORT1: s_axi_rdata[3:0] <= sync2_r[3:0];
                qnio_pkg::DEC_PORT2: s_axi_rdata[3:0] <= sync2_r[7:4];
                qnio_pkg::DEC_PORT3: s_axi_rdata[3:0] <= sync2_r[11:8];
                qnio_pkg::DEC_BITOP: s_axi_rdata[11:0] <= lat_r;
                qnio_pkg::DEC_TEST: s_axi_rdata[4:0] <= {test_level, test_sel_r};
                qnio_pkg::DEC_STBY: s_axi_rdata[0] <= halt_r;
                default: s_axi_rresp <= qnio_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_to(logic [2:0] code);
        wr_do && wr_dec == code;
    endsequence

    a_nibble_write: assert property (
        s_write_to(qnio_pkg::DEC_PORT1) |=> lat_r[3:0] == $past(wdata_r[3:0]))
        else $error("port one nibble not loaded");
    a_port_read: assert property (
        rd_take && rd_dec == qnio_pkg::DEC_PORT2 |=> s_axi_rdata[3:0] == $past(sync2_r[7:4]))
        else $error("port two read does not show pins");
    a_bit_test: assert property (
        rd_take && rd_dec == qnio_pkg::DEC_TEST
        |=> s_axi_rdata[4] == $past(sync2_r[test_sel_r]))
        else $error("bit test level wrong");
    a_bit_setclr: assert property (
        wr_do && wr_dec == qnio_pkg::DEC_BITOP && bitop_ok
        |=> lat_r[$past(wr_sel)] == $past(wr_set)
        && (lat_r & ~(12'h001 << $past(wr_sel))) == ($past(lat_r) & ~(12'h001 << $past(wr_sel))))
        else $error("bit operation disturbed other latches");
    a_wake_release: assert property (
        halt_r && wake_low && !(wr_do && wr_dec == qnio_pkg::DEC_STBY) |=> !halt_r && !standby)
        else $error("halt not released by wake pin");
    a_halt_hold: assert property (
        halt_r && !wake_low |=> halt_r)
        else $error("halt left without wake pin");
    a_drain_drive: assert property (
        port_one_pins_oe_n == lat_r[3:0] && port_one_pins_out == 4'h0)
        else $error("port one drive does not follow latch");
    a_reset_level: assert property (
        $rose(aresetn) |-> lat_r[7:4] == {4{P2_RESET_HIGH}} && lat_r[11:8] == {4{P3_RESET_HIGH}})
        else $error("reset level of ports two and three wrong");
    a_port1_reset: assert property (
        $rose(aresetn) |-> port_one_pins_oe_n == qnio_pkg::PORT1_RESET)
        else $error("port one not released high at reset");
endmodule // qnio_ports

//--- qnio_pin_model.sv
// Outside circuit model for one open-drain nibble port
`timescale 1ns/1ps
module qnio_pin_model (
    input wire logic clk,
    input wire logic [3:0] oe_n,
    input wire logic [3:0] pullup_en,
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    output logic [3:0] level
);
    logic [3:0] flt = 4'h0;
    // Undriven open pin wanders each cycle
    always @(posedge clk) flt <= ~flt;
    // Sink wins, then outside driver, then pull-up
    assign level = oe_n & ((ext_en & ext_val) | (~ext_en & (pullup_en | flt)));
endmodule // qnio_pin_model

//--- test_quad_nibble_io_ports.sv
// Testbench for the nibble ports: bus tasks, scenarios, verdict
`timescale 1ns/1ps
module test_quad_nibble_io_ports;
    localparam logic [3:0] P1U = 4'h6;
    localparam logic [3:0] P2U = 4'h3;
    localparam logic [3:0] P3U = 4'hC;
    localparam logic [1:0] OK = qnio_pkg::RESP_OKAY;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic standby;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] p1_in, p2_in, p3_in, p1_oe, p2_oe, p3_oe, p1_pu, p2_pu, p3_pu;
    logic [3:0] e1_en, e1_v, e2_en, e2_v, e3_en, e3_v;
    logic [3:0] p1_out, p2_out, p3_out;
    wire [11:0] oe_all = {p3_oe, p2_oe, p1_oe};
    int err_count = 0;
    int compares = 0;
    logic [11:0] cur;
    logic [3:0] pv [3] = '{4'hA, 4'h5, 4'hC};
    qnio_ports #(.P1_PULLUP(P1U), .P2_PULLUP(P2U), .P3_PULLUP(P3U), .P2_RESET_HIGH(1'b1),
        .P3_RESET_HIGH(1'b0)) qnio_ports_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .port_one_pins_in(p1_in), .port_one_pins_out(p1_out), .port_one_pins_oe_n(p1_oe),
        .port_one_pullup_en(p1_pu), .port_two_pins_in(p2_in), .port_two_pins_out(p2_out),
        .port_two_pins_oe_n(p2_oe), .port_two_pullup_en(p2_pu),
        .port_three_pins_in(p3_in), .port_three_pins_out(p3_out),
        .port_three_pins_oe_n(p3_oe),
        .port_three_pullup_en(p3_pu), .standby(standby));
    qnio_pin_model m1 (.clk(aclk), .oe_n(p1_oe), .pullup_en(p1_pu), .ext_en(e1_en),
        .ext_val(e1_v), .level(p1_in));
    qnio_pin_model m2 (.clk(aclk), .oe_n(p2_oe), .pullup_en(p2_pu), .ext_en(e2_en),
        .ext_val(e2_v), .level(p2_in));
    qnio_pin_model m3 (.clk(aclk), .oe_n(p3_oe), .pullup_en(p3_pu), .ext_en(e3_en),
        .ext_val(e3_v), .level(p3_in));
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk("rdata", rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask
    task automatic test_done();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        test_done();
    end
    initial begin
        aresetn = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        e1_en = 4'h9;
        e1_v = 4'h9;
        e2_en = 4'hC;
        e2_v = 4'hC;
        e3_en = 4'h3;
        e3_v = 4'h3;
        repeat (12) @(negedge aclk);
        chk("p1 rst", {28'h0, p1_oe}, 32'hF);
        chk("p2 rst", {28'h0, p2_oe}, 32'hF);
        chk("p3 rst", {28'h0, p3_oe}, 32'h0);
        chk("pullups", {20'h0, p3_pu, p2_pu, p1_pu}, {20'h0, P3U, P2U, P1U});
        chk("drive", {20'h0, p3_out, p2_out, p1_out}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            wchk(8'(4 * p), {28'h0, pv[p]}, OK);
            settle();
            chk("latch", {28'h0, oe_all[4*p +: 4]}, {28'h0, pv[p]});
            rchk(8'(4 * p), {28'h0, pv[p]}, OK);
        end
        e1_en <= 4'hB;
        e1_v <= 4'h9;
        settle();
        rchk(qnio_pkg::ADDR_PORT1, 32'h8, OK);
        rchk(qnio_pkg::ADDR_BITOP, 32'hC5A, OK);
        e1_en <= 4'h9;
        cur = 12'hC5A;
        for (int k = 0; k < 12; k++) begin
            wchk(qnio_pkg::ADDR_BITOP, {27'h0, 1'b0, 4'(k)}, OK);
            chk("clr", {20'h0, oe_all}, {20'h0, cur & ~(12'h1 << k)});
            cur = cur | (12'h1 << k);
            wchk(qnio_pkg::ADDR_BITOP, {27'h0, 1'b1, 4'(k)}, OK);
            chk("set", {20'h0, oe_all}, {20'h0, cur});
        end
        wchk(qnio_pkg::ADDR_BITOP, 32'h0C, OK);
        chk("no port", {20'h0, oe_all}, 32'hFFF);
        wchk(qnio_pkg::ADDR_PORT1, 32'h3, OK);
        wchk(qnio_pkg::ADDR_PORT2, 32'hA, OK);
        wchk(qnio_pkg::ADDR_PORT3, 32'h5, OK);
        cur = 12'h5A3;
        settle();
        for (int k = 0; k < 12; k++) begin
            wchk(qnio_pkg::ADDR_TEST, 32'(k), OK);
            rchk(qnio_pkg::ADDR_TEST, {27'h0, cur[k], 4'(k)}, OK);
        end
        wchk(qnio_pkg::ADDR_PORT1, 32'hF, OK);
        settle();
        wchk(qnio_pkg::ADDR_STBY, 32'h1, OK);
        chk("halt", {31'h0, standby}, 32'h1);
        rchk(qnio_pkg::ADDR_STBY, 32'h1, OK);
        wchk(qnio_pkg::ADDR_PORT2, 32'h7, OK);
        settle();
        chk("p2 wake", {31'h0, standby}, 32'h1);
        e1_v <= 4'h1;
        settle();
        chk("wake", {31'h0, standby}, 32'h0);
        e1_v <= 4'h9;
        settle();
        wchk(qnio_pkg::ADDR_STBY, 32'h1, OK);
        chk("halt again", {31'h0, standby}, 32'h1);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("rst2", {20'h0, oe_all}, 32'h0FF);
        chk("rst2 halt", {31'h0, standby}, 32'h0);
        chk("rst2 drive", {20'h0, p3_out, p2_out, p1_out}, 32'h0);
        aresetn <= 1'b1;
        wchk(8'h18, 32'h1, qnio_pkg::RESP_SLVERR);
        rchk(8'h18, 32'h0, qnio_pkg::RESP_SLVERR);
        test_done();
    end
endmodule // test_quad_nibble_io_ports
